// ---- dv/srw_host_model.sv ----
// Host model: drives the decoded kick levels and an external timebase.
// Assumes the bench's 100 MHz clock and bench-driven service requests.
`timescale 1ns/1ps

module srw_host_model
(
    input  wire logic clk,
    input  wire logic service,
    input  wire logic park_mid,
    input  wire logic ext_run,
    output logic      kick_high,
    output logic      kick_low,
    output logic      kick_mid,
    output logic      ext_clk
);
    // ------------------------------------------------------------
    // Kick and timebase generation
    // ------------------------------------------------------------
    logic [7:0] div_reg = 8'h00;  // Free counter pacing kicks and timebase.
    logic       lvl_reg = 1'b1;   // Firm kick level the host holds.

    // Toggles the kick every 256 clocks, well inside the shortest period.
    always_ff @(posedge clk)
    begin
        div_reg <= div_reg + 8'h01;
        if (service && div_reg == 8'hff)
        begin
            lvl_reg <= ~lvl_reg;
        end
    end

    // Exactly one decoded level is high, the middle one while parked.
    assign kick_mid  = park_mid;
    assign kick_high = ~park_mid & lvl_reg;
    assign kick_low  = ~park_mid & ~lvl_reg;

    // The timebase stands low unless asked to run, then cycles every 8 clocks.
    assign ext_clk = ext_run & div_reg[2];
endmodule

// ---- dv/supervisor_reset_watchdog_test.sv ----
// Self-checking bench for the supervisor core and its host model.
// Assumes a 100 MHz clock and TICK_CYC shrunk to 10 clocks per tick.
`timescale 1ns/1ps

module supervisor_reset_watchdog_test;
    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    logic        clk, resetn, rd, wr, sup_low, batt_low, pf, cs_n, sel, pin;
    logic        service, park, ext_run;
    logic [3:0]  addr, be;
    logic [31:0] wdata, rdata, q;
    wire logic   wait_req, kh, kl, km, ext_clk, tb_in;
    wire logic   rst_n, rst, fault, warn, cs_out, batt, low_n;
    int          bad_count, checks_done, cyc, n;

    // The timebase pin carries the period choice or the external clock.
    assign tb_in = sel ? pin : ext_clk;

    srw_supervisor #(.TICK_CYC(10)) dut
    (
        .clk(clk), .resetn(resetn), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(wait_req), .supply_low_in(sup_low),
        .supply_below_batt_in(batt_low), .power_fail_sense_in(pf),
        .watchdog_kick_high_in(kh), .watchdog_kick_low_in(kl), .watchdog_kick_mid_in(km),
        .chip_select_n_in(cs_n), .timebase_select(sel), .timebase_in(tb_in),
        .reset_n_out(rst_n), .reset_out(rst), .watchdog_fault_out(fault),
        .power_fail_warn_out(warn), .chip_select_n_out(cs_out),
        .backup_active_out(batt), .low_line_n_out(low_n)
    );

    srw_host_model host
    (
        .clk(clk), .service(service), .park_mid(park), .ext_run(ext_run),
        .kick_high(kh), .kick_low(kl), .kick_mid(km), .ext_clk(ext_clk)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Compares one output level.
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask

    // Compares a measured cycle count against a window.
    task automatic check_span(input string what, input int lo, input int hi, input int got);
        checks_done++;
        if (got < lo || got > hi)
        begin
            bad_count++;
            $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // Compares a register word.
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits, sampling settled values, until reset shows lvl or max cycles pass.
    task automatic wait_rst(input logic lvl, input int max, output int cnt);
        cnt = 0;
        while (rst_n !== lvl && cnt < max)
        begin
            @(negedge clk);
            cnt++;
        end
    endtask

    // Lets k settled cycles pass.
    task automatic idle(input int k);
        repeat (k) @(negedge clk);
    endtask

    // One Avalon transfer, held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        be <= b;
        @(posedge clk);
        while (wait_req !== 1'b0)
        begin
            @(posedge clk);
            k++;
        end
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        check_span("bus wait", 1, 1, k);
    endtask

    // Drops the supply for a few cycles, then restores it.
    task automatic glitch();
        @(posedge clk);
        sup_low <= 1'b1;
        idle(5);
        check_bit("reset low", 1'b0, rst_n);
        check_bit("fault forced", 1'b1, fault);
        @(posedge clk);
        sup_low <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Power-up: immediate low-line release, delayed reset, gated select.
    task automatic t_power();
        check_bit("reset held", 1'b0, rst_n);
        check_bit("gated select", 1'b1, cs_out);
        @(posedge clk);
        sup_low <= 1'b0;
        idle(5);
        check_bit("low line", 1'b1, low_n);
        check_bit("select open", 1'b0, cs_out);
        check_bit("inverse", 1'b1, rst);
        wait_rst(1'b1, 4000, n);
        check_span("reset delay", 480, 530, n);
        check_bit("inverse", 1'b0, rst);
        $display("power test done");
    endtask

    // Warning and backup flags for every battery and power-fail comparator combination.
    task automatic t_flags();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            {batt_low, pf} <= 2'(i);
            idle(5);
            check_bit("warn", ~(i[0] | i[1]), warn);
            check_bit("backup", i[1], batt);
            check_bit("reset", ~i[1], rst_n);
        end
        // Restore a good supply so the later tests start out of reset.
        @(posedge clk);
        {batt_low, pf} <= 2'b00;
        wait_rst(1'b1, 4000, n);
        check_span("flag recovery", 480, 530, n);
        $display("flag test done");
    endtask

    // Watchdog: short and long periods, repeats, fault hold, middle level.
    task automatic t_dog();
        @(posedge clk);
        service <= 1'b0;
        wait_rst(1'b0, 4000, n);
        check_span("short period", 700, 1020, n);
        check_bit("fault", 1'b0, fault);
        wait_rst(1'b1, 4000, n);
        check_span("pulse width", 480, 520, n);
        wait_rst(1'b0, 4000, n);
        check_span("repeat", 480, 530, n);
        check_bit("fault held", 1'b0, fault);
        @(posedge clk);
        service <= 1'b1;
        idle(300);
        check_bit("fault cleared", 1'b1, fault);
        wait_rst(1'b1, 4000, n);
        @(posedge clk);
        pin <= 1'b1;
        service <= 1'b0;
        wait_rst(1'b0, 20000, n);
        check_span("long period", 15700, 16020, n);
        @(posedge clk);
        park <= 1'b1;
        idle(5);
        check_bit("fault middle", 1'b1, fault);
        wait_rst(1'b1, 4000, n);
        wait_rst(1'b0, 2000, n);
        check_span("disabled", 2000, 2000, n);
        @(posedge clk);
        park <= 1'b0;
        service <= 1'b1;
        pin <= 1'b0;
        $display("watchdog test done");
    endtask

    // Registers, unmapped space, refused write, long reset delay.
    task automatic t_regs();
        bus(1'b1, 4'h0, 32'h00000001, 4'hf, q);
        bus(1'b1, 4'h0, 32'h00000002, 4'he, q);
        bus(1'b0, 4'h0, 32'h0, 4'hf, q);
        check_word("ctrl", 32'h00000001, q);
        bus(1'b0, 4'hc, 32'h0, 4'hf, q);
        check_word("unmapped", 32'h0, q);
        bus(1'b0, 4'h4, 32'h0, 4'hf, q);
        check_word("status", {24'h0, srw_pkg::SRW_RUN, 6'h33}, q);
        glitch();
        wait_rst(1'b1, 4000, n);
        check_span("long delay", 1980, 2030, n);
        bus(1'b1, 4'h0, 32'h0, 4'hf, q);
        $display("register test done");
    endtask

    // External timebase: no ticks hold reset, running ticks release it.
    task automatic t_ext();
        @(posedge clk);
        sel <= 1'b0;
        glitch();
        wait_rst(1'b1, 3000, n);
        check_span("stalled", 3000, 3000, n);
        @(posedge clk);
        ext_run <= 1'b1;
        wait_rst(1'b1, 4000, n);
        check_span("ext delay", 1000, 1060, n);
        // Short external period: 768 to 1025 timebase cycles of 8 clocks.
        bus(1'b1, 4'h0, 32'h00000002, 4'hf, q);
        @(posedge clk);
        service <= 1'b0;
        wait_rst(1'b0, 9000, n);
        check_span("ext short period", 6144, 8200, n);
        @(posedge clk);
        service <= 1'b1;
        $display("external test done");
    endtask

    // Closing report and verdict.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cuts a hang short well beyond the expected run length.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    initial
    begin
        {resetn, rd, wr, batt_low, pf, cs_n, pin, park, ext_run} = '0;
        {sup_low, sel, service} = 3'b111;
        {addr, be, wdata} = '0;
        {bad_count, checks_done, cyc} = '0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        idle(2);
        t_power();
        t_flags();
        t_dog();
        t_regs();
        t_ext();
        end_of_test();
    end
endmodule

// ---- include/srw_pkg.sv ----
// Constants shared by the supervisor core: register map, field positions,
// reset values and timing counts.
// Assumes a 100 MHz system clock and word-aligned Avalon-MM byte addresses.
package srw_pkg;

    // ----------------------------------------------------------------
    // Clock and timebase
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;         // System clock period in ns.
    localparam int unsigned INT_TICK_NS   = 1000000;    // Internal tick is one millisecond.
    localparam int unsigned INT_TICK_CYC  = INT_TICK_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Delays in ticks of the selected timebase
    // ----------------------------------------------------------------
    localparam int unsigned RST_DELAY_MS      = 50;     // Short reset delay in ms.
    localparam int unsigned RST_DELAY_LONG_MS = 200;    // Longer-delay variant in ms.
    localparam int unsigned WD_LONG_MS        = 1600;   // Internal long watchdog period in ms.
    localparam int unsigned WD_SHORT_MS       = 100;    // Internal short watchdog period in ms.
    localparam int unsigned EXT_WD_LONG_CYC   = 4096;   // External long period in timebase cycles.
    localparam int unsigned EXT_WD_SHORT_CYC  = 1024;   // External short period in timebase cycles.
    localparam int unsigned EXT_RST_CYC       = 128;    // External reset delay in cycles.
    localparam int unsigned EXT_RST_LONG_CYC  = 512;    // External long reset delay in cycles.
    localparam int unsigned CNT_W             = 13;     // Width of the delay counters.

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0]  CTRL_OFS    = 4'h0;         // Control register.
    localparam logic [3:0]  STATUS_OFS  = 4'h4;         // Status register.
    localparam logic [3:0]  WDCNT_OFS   = 4'h8;         // Watchdog count register.
    localparam int unsigned CTRL_LONG_RST_BIT = 0;      // Selects the long reset delay: 200 ms, or 512 external cycles.
    localparam int unsigned CTRL_EXT_SHORT_BIT = 1;     // Short period on external timebase.
    localparam logic [1:0]  CTRL_RESET  = 2'h0;         // Control value after reset.

    // Reset sequencer states, Gray coded along hold, delay, run.
    typedef enum logic [1:0]
    {
        SRW_HOLD  = 2'b00,
        SRW_DELAY = 2'b01,
        SRW_RUN   = 2'b11
    } srw_state_t;

endpackage

// ---- verilog/srw_supervisor.sv ----
// Digital core of a microprocessor supervisor: delayed power-on reset,
// three-level watchdog, chip-select gating and supply status flags.
// Assumes comparator results arrive as asynchronous digital levels and
// software reaches two control bits over an Avalon-MM slave port.
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps

module srw_supervisor
#(
    parameter int unsigned TICK_CYC = srw_pkg::INT_TICK_CYC  // Clocks per internal ms tick.
)
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        supply_low_in,
    input  wire logic        supply_below_batt_in,
    input  wire logic        power_fail_sense_in,
    input  wire logic        watchdog_kick_high_in,
    input  wire logic        watchdog_kick_low_in,
    input  wire logic        watchdog_kick_mid_in,
    input  wire logic        chip_select_n_in,
    input  wire logic        timebase_select,
    input  wire logic        timebase_in,
    output logic             reset_n_out,
    output logic             reset_out,
    output logic             watchdog_fault_out,
    output logic             power_fail_warn_out,
    output logic             chip_select_n_out,
    output logic             backup_active_out,
    output logic             low_line_n_out
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------

    // Two flip-flops per pin; only the second stage is read by logic.
    localparam int unsigned NSYNC = 9;
    logic [NSYNC-1:0] pin_meta_reg;   // First stage, read only by the second.
    logic [NSYNC-1:0] pin_sync_reg;   // Second stage, safe to use.
    wire  [NSYNC-1:0] pin_raw;        // Raw pin levels.

    assign pin_raw = {timebase_in, timebase_select, chip_select_n_in,
                      watchdog_kick_mid_in, watchdog_kick_low_in,
                      watchdog_kick_high_in, power_fail_sense_in,
                      supply_below_batt_in, supply_low_in};

    // Synchroniser pipeline; select resets high as if floating.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_meta_reg <= 9'h0c1;
            pin_sync_reg <= 9'h0c1;
        end
        else
        begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    wire low_s   = pin_sync_reg[0];   // Supply below reset threshold.
    wire batt_s  = pin_sync_reg[1];   // Supply below battery voltage.
    wire pf_s    = pin_sync_reg[2];   // Sense input below reference.
    wire khigh_s = pin_sync_reg[3];   // Kick input decoded high.
    wire klow_s  = pin_sync_reg[4];   // Kick input decoded low.
    wire kmid_s  = pin_sync_reg[5];   // Kick input at middle level.
    wire cs_s    = pin_sync_reg[6];   // Chip select in, active low.
    wire sel_s   = pin_sync_reg[7];   // High selects internal oscillator.
    wire tb_s    = pin_sync_reg[8];   // Timebase pin level.

    // ----------------------------------------------------------------
    // Register bus slave
    // ----------------------------------------------------------------

    logic [1:0]  ctrl_reg;            // Software control bits.
    logic        ack_reg;             // High in the cycle the answer stands.
    logic [31:0] rdata_reg;           // Captured read data.
    logic [srw_pkg::CNT_W-1:0] wd_cnt_reg;   // Watchdog count, read back.
    srw_pkg::srw_state_t       state_reg;    // Reset sequencer state.
    logic        fault_reg;           // Fault output, active low.
    logic        rst_n_reg;           // Reset output, active low.
    logic        pfw_reg;             // Power-fail warning output.
    logic        cs_out_reg;          // Gated chip select output.
    logic        batt_reg;            // Backup active output.
    logic        lowline_reg;         // Supply-low output, active low.

    wire req      = avs_read | avs_write;   // A request is pending.
    wire take     = req & ~ack_reg;         // First cycle of a request.
    wire hit_ctrl = (avs_address == srw_pkg::CTRL_OFS);
    wire hit_stat = (avs_address == srw_pkg::STATUS_OFS);
    wire hit_wd   = (avs_address == srw_pkg::WDCNT_OFS);
    wire ctrl_we  = avs_write & ack_reg & hit_ctrl & avs_byteenable[0];

    // Status word shows the block's own output levels.
    wire [31:0] status_word = {24'h0, state_reg, fault_reg, lowline_reg,
                               batt_reg, cs_out_reg, pfw_reg, rst_n_reg};

    // Read selection; unmapped addresses read as zero.
    wire [31:0] rdata_next = hit_ctrl ? {30'h0, ctrl_reg} :
                             hit_stat ? status_word :
                             hit_wd   ? {{(32-srw_pkg::CNT_W){1'b0}}, wd_cnt_reg} :
                                        32'h0;

    // Wait one cycle, then answer; the write lands at the answering edge.
    assign avs_waitrequest = req & ~ack_reg;
    assign avs_readdata    = rdata_reg;

    // Bus handshake and read capture.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0;
        end
        else
        begin
            ack_reg <= take;
            if (take && avs_read)
            begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // Control register write.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_reg <= srw_pkg::CTRL_RESET;
        end
        else if (ctrl_we)
        begin
            ctrl_reg <= avs_writedata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // Timebase
    // ----------------------------------------------------------------

    logic [31:0] pre_reg;             // Internal oscillator prescaler.
    logic        tb_last_reg;         // Previous timebase pin level.

    wire pre_tick = (pre_reg == TICK_CYC - 1);
    wire ext_tick = tb_s & ~tb_last_reg;     // Rising edge of external clock.
    wire tick     = sel_s ? pre_tick : ext_tick;

    // Prescaler and external edge detector.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pre_reg     <= 32'h0;
            tb_last_reg <= 1'b0;
        end
        else
        begin
            pre_reg     <= pre_tick ? 32'h0 : pre_reg + 32'h1;
            tb_last_reg <= tb_s;
        end
    end

    // Reset delay and watchdog period for the selected timebase.
    wire long_rst = ctrl_reg[srw_pkg::CTRL_LONG_RST_BIT];
    wire [srw_pkg::CNT_W-1:0] rst_len =
        sel_s ? (long_rst ? srw_pkg::CNT_W'(srw_pkg::RST_DELAY_LONG_MS)
                          : srw_pkg::CNT_W'(srw_pkg::RST_DELAY_MS))
              : (long_rst ? srw_pkg::CNT_W'(srw_pkg::EXT_RST_LONG_CYC)
                          : srw_pkg::CNT_W'(srw_pkg::EXT_RST_CYC));
    wire [srw_pkg::CNT_W-1:0] wd_len =
        sel_s ? (tb_s ? srw_pkg::CNT_W'(srw_pkg::WD_LONG_MS)
                      : srw_pkg::CNT_W'(srw_pkg::WD_SHORT_MS))
              : (ctrl_reg[srw_pkg::CTRL_EXT_SHORT_BIT]
                      ? srw_pkg::CNT_W'(srw_pkg::EXT_WD_SHORT_CYC)
                      : srw_pkg::CNT_W'(srw_pkg::EXT_WD_LONG_CYC));

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------

    logic kick_level_reg;             // Last firm kick level seen.
    logic kick_valid_reg;             // A firm level has been seen.

    wire kick_firm  = (khigh_s ^ klow_s) & ~kmid_s;
    wire kick_edge  = kick_firm & kick_valid_reg & (khigh_s != kick_level_reg);
    wire wd_enable  = kick_firm & ~low_s;
    wire wd_expire  = wd_enable & ~kick_edge & tick & (wd_cnt_reg == wd_len - 1'b1);

    // Kick level memory for transition detection.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            kick_level_reg <= 1'b0;
            kick_valid_reg <= 1'b0;
        end
        else if (kick_firm)
        begin
            kick_level_reg <= khigh_s;
            kick_valid_reg <= 1'b1;
        end
        else if (kmid_s)
        begin
            kick_valid_reg <= 1'b0;
        end
    end

    // Count ticks; a transition or expiry starts a new period.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wd_cnt_reg <= '0;
        end
        else if (!wd_enable || kick_edge || wd_expire)
        begin
            wd_cnt_reg <= '0;
        end
        else if (tick)
        begin
            wd_cnt_reg <= wd_cnt_reg + 1'b1;
        end
    end

    // Fault output: low on expiry, high on transition, middle or supply low.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fault_reg <= 1'b1;
        end
        else if (low_s || kmid_s || kick_edge)
        begin
            fault_reg <= 1'b1;
        end
        else if (wd_expire)
        begin
            fault_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Reset sequencer
    // ----------------------------------------------------------------

    logic [srw_pkg::CNT_W-1:0] rst_cnt_reg;   // Ticks spent in delay.
    wire supply_bad = low_s | batt_s;
    wire rst_done   = tick & (rst_cnt_reg == rst_len - 1'b1);

    // Hold while the supply is bad, then time the delay; expiry re-enters it.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg   <= srw_pkg::SRW_HOLD;
            rst_cnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                srw_pkg::SRW_HOLD:
                begin
                    rst_cnt_reg <= '0;
                    if (!supply_bad)
                    begin
                        state_reg <= srw_pkg::SRW_DELAY;
                    end
                end
                srw_pkg::SRW_DELAY:
                begin
                    if (supply_bad)
                    begin
                        state_reg <= srw_pkg::SRW_HOLD;
                    end
                    else if (rst_done)
                    begin
                        state_reg <= srw_pkg::SRW_RUN;
                    end
                    else if (tick)
                    begin
                        rst_cnt_reg <= rst_cnt_reg + 1'b1;
                    end
                end
                default:
                begin
                    rst_cnt_reg <= '0;
                    if (supply_bad)
                    begin
                        state_reg <= srw_pkg::SRW_HOLD;
                    end
                    else if (wd_expire)
                    begin
                        state_reg <= srw_pkg::SRW_DELAY;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------

    wire rst_n_next = (state_reg == srw_pkg::SRW_RUN) & ~supply_bad & ~wd_expire;

    // All pin outputs are registered from synchronised levels.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_n_reg   <= 1'b0;
            pfw_reg     <= 1'b0;
            cs_out_reg  <= 1'b1;
            batt_reg    <= 1'b0;
            lowline_reg <= 1'b0;
        end
        else
        begin
            rst_n_reg   <= rst_n_next;
            pfw_reg     <= ~(pf_s | batt_s);
            cs_out_reg  <= cs_s | low_s;
            batt_reg    <= batt_s;
            lowline_reg <= ~low_s;
        end
    end

    assign reset_n_out         = rst_n_reg;
    assign reset_out           = ~rst_n_reg;
    assign watchdog_fault_out  = fault_reg;
    assign power_fail_warn_out = pfw_reg;
    assign chip_select_n_out   = cs_out_reg;
    assign backup_active_out   = batt_reg;
    assign low_line_n_out      = lowline_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    a_reset_on_low: assert property (@(posedge clk) disable iff (!resetn)
        supply_bad |=> !reset_n_out)
        else $error("reset released while supply is bad");

    a_reset_held_delay: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == srw_pkg::SRW_HOLD && !supply_bad) |=> !reset_n_out [*2])
        else $error("reset released without delay");

    a_expiry_pulse: assert property (@(posedge clk) disable iff (!resetn)
        wd_expire |=> (!reset_n_out && state_reg == srw_pkg::SRW_DELAY))
        else $error("watchdog expiry gave no reset pulse");

    a_fault_on_expiry: assert property (@(posedge clk) disable iff (!resetn)
        (wd_expire && !low_s && !kmid_s) |=> !watchdog_fault_out)
        else $error("fault not driven low on expiry");

    a_mid_disables: assert property (@(posedge clk) disable iff (!resetn)
        kmid_s |=> (wd_cnt_reg == '0 && watchdog_fault_out))
        else $error("watchdog ran at middle kick level");

    a_edge_restarts: assert property (@(posedge clk) disable iff (!resetn)
        kick_edge |=> (wd_cnt_reg == '0 && watchdog_fault_out))
        else $error("kick transition did not restart watchdog");

    a_warn_forced: assert property (@(posedge clk) disable iff (!resetn)
        batt_s |=> (!power_fail_warn_out && backup_active_out))
        else $error("warning not forced low on battery");

    a_cs_gating: assert property (@(posedge clk) disable iff (!resetn)
        ##1 chip_select_n_out == ($past(cs_s) | $past(low_s)))
        else $error("chip select gating wrong");

    a_lowline_fast: assert property (@(posedge clk) disable iff (!resetn)
        (!low_s && $past(low_s)) |=> low_line_n_out)
        else $error("supply-low output delayed on recovery");

    a_reset_inverse: assert property (@(posedge clk) disable iff (!resetn)
        reset_out == !reset_n_out)
        else $error("active-high reset not inverse");

    a_fault_lowline: assert property (@(posedge clk) disable iff (!resetn)
        !low_line_n_out |-> watchdog_fault_out)
        else $error("fault low while supply low");

endmodule
